// ### rtl/mia_pkg.sv
// constants for the mcu interrupt aggregator
// assumes a 32-bit apb slave with 12-bit byte addresses
package mia_pkg;
  // ********************************
  // register map (byte addresses)
  // ********************************
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFF_EN = 12'h000;   // core_irq_enable
  localparam logic [11:0] OFF_IEP = 12'h004;  // in endpoint pending
  localparam logic [11:0] OFF_OEP = 12'h008;  // out endpoint pending
  localparam logic [11:0] OFF_VEC = 12'h00C;  // irq_vector_reg
  localparam logic [11:0] OFF_STAT = 12'h010; // sticky status, w1c
  localparam logic [11:0] OFF_MASK = 12'h014; // status mask

  // ********************************
  // enable register layout
  // ********************************
  localparam int EN_EXT0 = 0; // ext_irq_zero_en
  localparam int EN_T0 = 1;   // tmr_zero_irq_en
  localparam int EN_EXT1 = 2; // ext_irq_one_en
  localparam int EN_T1 = 3;   // tmr_one_irq_en
  localparam int EN_SER = 4;  // serial_irq_en
  localparam int EN_GLB = 7;  // global_irq_en
  localparam logic [7:0] EN_WMASK = 8'h9F; // bits 5,6 read zero
  localparam logic [7:0] EN_RST = 8'h00;

  // ********************************
  // core dispatch addresses
  // ********************************
  localparam logic [15:0] VA_RESET = 16'h0000;
  localparam logic [15:0] VA_EXT0 = 16'h0003;
  localparam logic [15:0] VA_T0 = 16'h000B;
  localparam logic [15:0] VA_EXT1 = 16'h0013;
  localparam logic [15:0] VA_T1 = 16'h001B;
  localparam logic [15:0] VA_SER = 16'h0023;

  // ********************************
  // vector slots: slot = group*8 + index
  // ********************************
  localparam int NGRP = 9;         // groups 0..8 exist
  localparam int SLOTS = 72;
  localparam logic [7:0] VEC_NONE = 8'h00;
  localparam logic [71:0] USED_MASK = 72'h0F1F0F0F0FF3FEFE00;
  localparam logic [71:0] EP_MASK = 72'h000000000C00FEFE00;
  localparam int G_OUTEP = 1;      // out endpoints 1..7
  localparam int G_INEP = 2;       // in endpoints 1..7
  localparam int SLOT_IEP0 = 34;   // group 4 index 2
  localparam int SLOT_OEP0 = 35;   // group 4 index 3

  // ********************************
  // interrupt status bits
  // ********************************
  localparam int STAT_W = 2;
  localparam int ST_VLOAD = 0;     // a vector was loaded
  localparam int ST_OVR = 1;       // event hit a pending slot
  localparam logic [1:0] STAT_RST = 2'h0;
endpackage : mia_pkg

// ### rtl/mia_fcfs_group.sv
// first-come-first-served pick among eight pending sources
// assumes pend is a registered level vector on clk
`timescale 1ns/10ps
`default_nettype none
module mia_fcfs_group (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] pend,
  output logic [2:0] winIdx,
  output logic winAny
);
  // ********************************
  // age matrix
  // ********************************
  logic [7:0] pendPrev_reg;   // pend one cycle ago
  logic [63:0] older_reg;     // [i*8+j]: i came before j
  logic [63:0] older_next;
  logic [7:0] newly;          // rising pend bits
  logic [7:0] isWin;          // no older pending peer

  assign newly = pend & ~pendPrev_reg;

  // ties on one edge go to the lower index
  always_comb begin
    older_next = older_reg;
    for (int i = 0; i < 8; i++) begin
      for (int j = 0; j < 8; j++) begin
        if (newly[i]) begin
          older_next[i*8+j] = newly[j] && (i < j);
        end else if (newly[j]) begin
          older_next[i*8+j] = pend[i];
        end
      end
    end
  end

  // oldest pending source wins; ranks come from older_next so a
  // source arriving this cycle is already younger than its peers,
  // and a stale age bit from its last life cannot block them
  always_comb begin
    isWin = 8'h00;
    winIdx = 3'h0;
    for (int i = 0; i < 8; i++) begin
      isWin[i] = pend[i];
      for (int j = 0; j < 8; j++) begin
        if (pend[j] && older_next[j*8+i]) begin
          isWin[i] = 1'b0;
        end
      end
    end
    for (int i = 7; i >= 0; i--) begin
      if (isWin[i]) begin
        winIdx = 3'(i);
      end
    end
  end
  assign winAny = |pend;

  // history registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pendPrev_reg <= 8'h00;
      older_reg <= 64'h0;
    end else begin
      pendPrev_reg <= pend;
      older_reg <= older_next;
    end
  end
endmodule : mia_fcfs_group
`default_nettype wire

// ### rtl/mia_top.sv
// interrupt aggregator around an embedded 8-bit core
// assumes apb master on clk, single-cycle event pulses
//
// Overview of operation
// - five core sources, each with enable bit
// - serial 0023h, timer-1 001Bh, ext-1 0013h
// - ext-0 0003h, timer-0 000Bh, reset 0000h
// - peripheral requests ORed into ext-0
// - active-low pin carries combined request
// - enable bits 0..4 per source, reset 0
// - bit 7 global enable, 5,6 reserved
// - ext-0 driven only by internal request
// - vector register names source, 64 vectors
// - in-endpoint pending bits set by events
// - out-endpoint pending bits set by events
// - vector write clears endpoint pending bit
// - vector write loads next; idle reads 00h
// - vector: group 7..4, source 3..1, bit0 0
// - higher group first, fcfs in group
//
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/10ps
`default_nettype none
module mia_top (
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tmrZeroReq,
  input wire logic extOneReq,
  input wire logic tmrOneReq,
  input wire logic serialReq,
  input wire logic [7:0] inEpEvent,
  input wire logic [7:0] outEpEvent,
  input wire logic [71:0] periphEvent,
  output logic [4:0] coreIrqReq,
  output logic [15:0] coreDispatchAddr,
  output logic coreIrqZeroLine_n,
  output logic combinedIrqOut_n,
  output logic irq
);
  // ********************************
  // apb decode
  // ********************************
  logic setup;       // first cycle of a transfer
  logic access;      // access phase
  logic hitEn;
  logic hitIep;
  logic hitOep;
  logic hitVec;
  logic hitStat;
  logic hitMask;
  logic hit;         // any mapped word
  logic wrEn;
  logic wrVec;       // any write value counts
  logic wrStat;
  logic wrMask;

  assign setup = psel && !penable;
  assign access = psel && penable;
  assign hitEn = (paddr == mia_pkg::OFF_EN);
  assign hitIep = (paddr == mia_pkg::OFF_IEP);
  assign hitOep = (paddr == mia_pkg::OFF_OEP);
  assign hitVec = (paddr == mia_pkg::OFF_VEC);
  assign hitStat = (paddr == mia_pkg::OFF_STAT);
  assign hitMask = (paddr == mia_pkg::OFF_MASK);
  assign hit = hitEn | hitIep | hitOep | hitVec | hitStat | hitMask;
  assign wrEn = access && pwrite && hitEn;
  assign wrVec = access && pwrite && hitVec;
  assign wrStat = access && pwrite && hitStat;
  assign wrMask = access && pwrite && hitMask;
  // zero wait state: read data is staged in setup
  assign pready = 1'b1;
  assign pslverr = access && !hit;

  // ********************************
  // state registers
  // ********************************
  logic [7:0] enable_reg;          // core_irq_enable
  logic [7:0] enable_next;
  logic [71:0] pend_reg;           // one bit per vector slot
  logic [71:0] pend_next;
  logic [7:0] vec_reg;             // irq_vector_reg
  logic [7:0] vec_next;
  logic [1:0] stat_reg;            // sticky status
  logic [1:0] stat_next;
  logic [1:0] mask_reg;
  logic [1:0] mask_next;
  logic [15:0] dispatch_reg;       // address to core
  logic [15:0] dispatch_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;

  // ********************************
  // core interrupt gating
  // ********************************
  logic combinedReq;   // any peripheral slot pending
  logic [4:0] coreSrc; // serial, t1, x1, t0, x0

  assign combinedReq = |pend_reg;
  // internal line only; no ext-0 pin is sampled
  assign coreSrc = {serialReq, tmrOneReq, extOneReq, tmrZeroReq,
                    combinedReq};
  assign coreIrqReq = enable_reg[mia_pkg::EN_GLB] ?
                      (coreSrc & enable_reg[4:0]) : 5'h00;
  // low level held while pending, so level mode keeps seeing it
  assign coreIrqZeroLine_n = !combinedReq;
  assign combinedIrqOut_n = !combinedReq;

  // fixed core priority: ext-0 first, serial last
  always_comb begin
    if (coreIrqReq[mia_pkg::EN_EXT0]) begin
      dispatch_next = mia_pkg::VA_EXT0;
    end else if (coreIrqReq[mia_pkg::EN_T0]) begin
      dispatch_next = mia_pkg::VA_T0;
    end else if (coreIrqReq[mia_pkg::EN_EXT1]) begin
      dispatch_next = mia_pkg::VA_EXT1;
    end else if (coreIrqReq[mia_pkg::EN_T1]) begin
      dispatch_next = mia_pkg::VA_T1;
    end else if (coreIrqReq[mia_pkg::EN_SER]) begin
      dispatch_next = mia_pkg::VA_SER;
    end else begin
      dispatch_next = mia_pkg::VA_RESET;
    end
  end
  assign coreDispatchAddr = dispatch_reg;

  // reserved bits 5,6 never store
  assign enable_next = wrEn ? (pwdata[7:0] & mia_pkg::EN_WMASK)
                            : enable_reg;

  // ********************************
  // pending slots
  // ********************************
  logic [71:0] epSet;       // endpoint events by slot
  logic [71:0] setVec;      // all events by slot
  logic [71:0] clrVec;      // slot served by a write
  logic [7:0] inEpView;     // in endpoint pending
  logic [7:0] outEpView;    // out endpoint pending
  logic [6:0] curSlot;      // slot of current vector

  // endpoints 1..7 sit in groups 1 and 2, endpoint 0 in group 4
  always_comb begin
    epSet = 72'h0;
    inEpView = 8'h00;
    outEpView = 8'h00;
    for (int n = 1; n < 8; n++) begin
      epSet[mia_pkg::G_INEP*8+n] = inEpEvent[n];
      epSet[mia_pkg::G_OUTEP*8+n] = outEpEvent[n];
      inEpView[n] = pend_reg[mia_pkg::G_INEP*8+n];
      outEpView[n] = pend_reg[mia_pkg::G_OUTEP*8+n];
    end
    epSet[mia_pkg::SLOT_IEP0] = inEpEvent[0];
    epSet[mia_pkg::SLOT_OEP0] = outEpEvent[0];
    inEpView[0] = pend_reg[mia_pkg::SLOT_IEP0];
    outEpView[0] = pend_reg[mia_pkg::SLOT_OEP0];
  end

  // unused slots never set, so idle groups stay quiet
  assign setVec = epSet | (periphEvent & mia_pkg::USED_MASK
                           & ~mia_pkg::EP_MASK);
  assign curSlot = vec_reg[7:1];
  assign clrVec = (wrVec && vec_reg != mia_pkg::VEC_NONE) ?
                  (72'h1 << curSlot) : 72'h0;
  // a new event on the served slot survives the clear
  assign pend_next = (pend_reg & ~clrVec) | setVec;

  // ********************************
  // vector priority
  // ********************************
  logic [2:0] grpIdx [9];   // fcfs winner per group
  logic [8:0] grpAny;       // group has a pending slot
  logic [3:0] topGroup;     // highest pending group
  logic [2:0] topIdx;

  assign grpAny[0] = 1'b0;
  assign grpIdx[0] = 3'h0;
  genvar g;
  generate
    for (g = 1; g < mia_pkg::NGRP; g++) begin : gGrp
      mia_fcfs_group uGrp (
        .clk(clk),
        .nrst(nrst),
        .pend(pend_reg[g*8 +: 8]),
        .winIdx(grpIdx[g]),
        .winAny(grpAny[g])
      );
    end
  endgenerate

  // later groups overwrite, so the highest wins
  always_comb begin
    topGroup = 4'h0;
    topIdx = 3'h0;
    for (int k = 1; k < mia_pkg::NGRP; k++) begin
      if (grpAny[k]) begin
        topGroup = 4'(k);
        topIdx = grpIdx[k];
      end
    end
  end

  // vector holds while served, so a late high source waits
  always_comb begin
    if (wrVec) begin
      vec_next = mia_pkg::VEC_NONE;
    end else if (vec_reg == mia_pkg::VEC_NONE && combinedReq) begin
      vec_next = {topGroup, topIdx, 1'b0};
    end else begin
      vec_next = vec_reg;
    end
  end

  // ********************************
  // sticky status and interrupt
  // ********************************
  logic [1:0] statEvt;
  logic vecLoad;

  assign vecLoad = !wrVec && vec_reg == mia_pkg::VEC_NONE
                   && combinedReq;
  assign statEvt = {|(setVec & pend_reg & ~clrVec), vecLoad};
  // set wins over a same-cycle one-write
  assign stat_next = (stat_reg & ~(wrStat ? pwdata[1:0] : 2'h0))
                     | statEvt;
  assign mask_next = wrMask ? pwdata[1:0] : mask_reg;
  assign irq = |(stat_reg & mask_reg);

  // ********************************
  // read path
  // ********************************
  logic [31:0] rdMux;

  // reads have no side effects
  always_comb begin
    rdMux = 32'h0;
    if (hitEn) begin
      rdMux = {24'h0, enable_reg};
    end else if (hitIep) begin
      rdMux = {24'h0, inEpView};
    end else if (hitOep) begin
      rdMux = {24'h0, outEpView};
    end else if (hitVec) begin
      rdMux = {24'h0, vec_reg};
    end else if (hitStat) begin
      rdMux = {30'h0, stat_reg};
    end else if (hitMask) begin
      rdMux = {30'h0, mask_reg};
    end
  end
  assign prdata_next = (setup && !pwrite) ? rdMux : prdata_reg;
  assign prdata = prdata_reg;

  // ********************************
  // flip-flops
  // ********************************
  // everything clears, so no core request or irq fires before firmware; the pins still follow pending slots
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      enable_reg <= mia_pkg::EN_RST;
      pend_reg <= 72'h0;
      vec_reg <= mia_pkg::VEC_NONE;
      stat_reg <= mia_pkg::STAT_RST;
      mask_reg <= 2'h0;
      dispatch_reg <= mia_pkg::VA_RESET;
      prdata_reg <= 32'h0;
    end else begin
      enable_reg <= enable_next;
      pend_reg <= pend_next;
      vec_reg <= vec_next;
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      dispatch_reg <= dispatch_next;
      prdata_reg <= prdata_next;
    end
  end

  // ********************************
  // checks
  // ********************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  property p_en_write;
    wrEn |=> enable_reg == ($past(pwdata[7:0]) & 8'h9F);
  endproperty
  a_en_write: assert property (p_en_write)
    else $error("enable write not stored");

  property p_global_off;
    !enable_reg[7] |-> coreIrqReq == 5'h00;
  endproperty
  a_global_off: assert property (p_global_off)
    else $error("request passed with global enable off");

  property p_x0_addr;
    coreIrqReq[0] |=> coreDispatchAddr == 16'h0003;
  endproperty
  a_x0_addr: assert property (p_x0_addr)
    else $error("ext-0 dispatch address wrong");

  property p_serial_addr;
    coreIrqReq == 5'h10 |=> coreDispatchAddr == 16'h0023;
  endproperty
  a_serial_addr: assert property (p_serial_addr)
    else $error("serial dispatch address wrong");

  property p_pin_low;
    combinedIrqOut_n == !(|pend_reg) && coreIrqZeroLine_n == !(|pend_reg);
  endproperty
  a_pin_low: assert property (p_pin_low)
    else $error("combined pin not low while pending");

  property p_ep_set;
    (|inEpEvent) |=> (inEpView & $past(inEpEvent)) == $past(inEpEvent);
  endproperty
  a_ep_set: assert property (p_ep_set)
    else $error("endpoint pending not set");

  property p_ep_out_set;
    (|outEpEvent) |=> (outEpView & $past(outEpEvent)) == $past(outEpEvent);
  endproperty
  a_ep_out_set: assert property (p_ep_out_set)
    else $error("out endpoint pending not set");

  property p_ep_clear;
    wrVec && vec_reg == 8'h26 && !inEpEvent[3] |=> !inEpView[3];
  endproperty
  a_ep_clear: assert property (p_ep_clear)
    else $error("endpoint pending not cleared by write");

  property p_vec_reload;
    wrVec ##1 (combinedReq && !wrVec) |-> vec_reg == 8'h00
      ##1 vec_reg != 8'h00;
  endproperty
  a_vec_reload: assert property (p_vec_reload)
    else $error("vector not reloaded after write");

  property p_vec_prio;
    vecLoad |=> vec_reg[7:4] == $past(topGroup) && !vec_reg[0];
  endproperty
  a_vec_prio: assert property (p_vec_prio)
    else $error("vector not from highest group");

  property p_irq_out;
    vecLoad |=> stat_reg[0] && !vec_reg[0] && vec_reg[7:4] != 4'h0
      && (irq || !mask_reg[0]);
  endproperty
  a_irq_out: assert property (p_irq_out)
    else $error("vector load not flagged or malformed");
endmodule : mia_top
`default_nettype wire

// ### sim/mia_ext_mcu.sv
// model of the external mcu that listens on the combined pin
// assumes the pin is active low and sampled on clk
`timescale 1ns/10ps
`default_nettype none
module mia_ext_mcu (
  input wire logic clk,
  input wire logic nrst,
  input wire logic irqPin_n,
  output logic irqSeen
);
  // ********************************
  // level sensing
  // ********************************
  // level, never edge: a source still pending after service
  // keeps interrupting instead of being lost
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irqSeen <= 1'b0; // nothing seen in reset
    end else begin
      irqSeen <= ~irqPin_n;
    end
  end
endmodule : mia_ext_mcu
`default_nettype wire

// ### sim/mcu_interrupt_aggregator_tb.sv
// self-checking bench for the interrupt aggregator
// assumes apb at 100 MHz and single-cycle event pulses
`timescale 1ns/10ps
`default_nettype none
module mcu_interrupt_aggregator_tb;
  logic clk, nrst, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic tmrZeroReq, extOneReq, tmrOneReq, serialReq;
  logic [7:0] inEpEvent, outEpEvent;
  logic [71:0] periphEvent;
  logic [4:0] coreIrqReq;
  logic [15:0] coreDispatchAddr;
  logic coreIrqZeroLine_n, combinedIrqOut_n, irqSeen;
  int numErrors = 0; // mismatches so far
  int testsRun = 0; // comparisons so far

  mia_top i_dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tmrZeroReq(tmrZeroReq),
    .extOneReq(extOneReq), .tmrOneReq(tmrOneReq), .serialReq(serialReq),
    .inEpEvent(inEpEvent), .outEpEvent(outEpEvent),
    .periphEvent(periphEvent), .coreIrqReq(coreIrqReq),
    .coreDispatchAddr(coreDispatchAddr),
    .coreIrqZeroLine_n(coreIrqZeroLine_n),
    .combinedIrqOut_n(combinedIrqOut_n), .irq(irq));
  mia_ext_mcu i_mcu (.clk(clk), .nrst(nrst), .irqPin_n(combinedIrqOut_n),
    .irqSeen(irqSeen));

  // ********************************
  // clock, verdict and compare
  // ********************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic testDone();
    if (numErrors == 0 && testsRun > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : testDone
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      numErrors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // ********************************
  // apb master, entered just after an edge
  // ********************************
  task automatic apbXfer(input logic [11:0] a, input logic w,
      input logic [31:0] wd, output logic [31:0] rd, output logic err);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      numErrors++;
      $display("Error at %0t: no pready", $time);
      testDone();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apbXfer
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apbXfer(a, 1'b1, d, r, e);
  endtask : wr
  task automatic rdChk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apbXfer(a, 1'b0, 32'h0, r, e);
    chk(r, exp);
  endtask : rdChk
  // one-cycle event pulse, then one idle edge
  task automatic pulse(input logic [7:0] ie, input logic [7:0] oe,
      input logic [71:0] pe);
    inEpEvent <= ie;
    outEpEvent <= oe;
    periphEvent <= pe;
    @(posedge clk);
    inEpEvent <= 8'h00;
    outEpEvent <= 8'h00;
    periphEvent <= '0;
    @(posedge clk);
  endtask : pulse

  // ********************************
  // scenarios
  // ********************************
  task automatic sReset();
    rdChk(mia_pkg::OFF_EN, 32'h0);
    rdChk(mia_pkg::OFF_IEP, 32'h0);
    rdChk(mia_pkg::OFF_OEP, 32'h0);
    rdChk(mia_pkg::OFF_VEC, 32'h0);
    chk({combinedIrqOut_n, coreIrqZeroLine_n}, 32'h3);
    chk({irq, coreIrqReq, coreDispatchAddr}, 32'h0);
  endtask : sReset
  task automatic sCore();
    logic [15:0] va [5];
    logic [31:0] r;
    logic e;
    va = '{16'h0000, 16'h000B, 16'h0013, 16'h001B, 16'h0023};
    tmrZeroReq <= 1'b1;
    extOneReq <= 1'b1;
    tmrOneReq <= 1'b1;
    serialReq <= 1'b1;
    wr(mia_pkg::OFF_EN, 32'hFF);
    rdChk(mia_pkg::OFF_EN, 32'h9F);
    // ext-0 has nothing pending, so bit 0 alone asks nothing
    for (int i = 0; i < 5; i++) begin
      wr(mia_pkg::OFF_EN, 32'h80 | (32'h1 << i));
      tick(2);
      chk(coreIrqReq, (i == 0) ? 32'h0 : (32'h1 << i));
      chk(coreDispatchAddr, va[i]);
    end
    wr(mia_pkg::OFF_EN, 32'h1F);
    tick(2);
    chk({coreIrqReq, coreDispatchAddr}, 32'h0);
    wr(mia_pkg::OFF_IEP, 32'hFF);
    rdChk(mia_pkg::OFF_IEP, 32'h0);
    // unmapped word: error flag in access, read data zero
    apbXfer(12'h020, 1'b0, 32'h0, r, e);
    chk(e, 32'h1);
    chk(r, 32'h0);
  endtask : sCore
  task automatic sEndpoint();
    wr(mia_pkg::OFF_EN, 32'h81);
    pulse(8'h08, 8'h00, '0);
    tick(2);
    chk({combinedIrqOut_n, coreIrqZeroLine_n}, 32'h0);
    chk(irqSeen, 32'h1);
    chk({coreIrqReq, coreDispatchAddr}, {5'h01, 16'h0003});
    rdChk(mia_pkg::OFF_IEP, 32'h08);
    rdChk(mia_pkg::OFF_VEC, 32'h26);
    wr(mia_pkg::OFF_VEC, 32'h0);
    tick(1);
    rdChk(mia_pkg::OFF_IEP, 32'h0);
    rdChk(mia_pkg::OFF_VEC, 32'h0);
    chk({combinedIrqOut_n, coreIrqZeroLine_n}, 32'h3);
    pulse(8'h00, 8'h01, '0);
    tick(2);
    rdChk(mia_pkg::OFF_OEP, 32'h01);
    rdChk(mia_pkg::OFF_VEC, 32'h46);
    wr(mia_pkg::OFF_VEC, 32'h0);
    tick(1);
    rdChk(mia_pkg::OFF_OEP, 32'h0);
  endtask : sEndpoint
  task automatic sPriority();
    logic [7:0] order [5];
    order = '{8'h80, 8'h2A, 8'h24, 8'h1E, 8'h00};
    pulse(8'h00, 8'h00, 72'h1 << 64);
    pulse(8'h20, 8'h00, '0);
    pulse(8'h04, 8'h80, '0);
    tick(2);
    // higher group first, then arrival order inside group 2
    for (int i = 0; i < 5; i++) begin
      rdChk(mia_pkg::OFF_VEC, {24'h0, order[i]});
      wr(mia_pkg::OFF_VEC, 32'h0);
      tick(2);
    end
    chk({combinedIrqOut_n, coreIrqZeroLine_n}, 32'h3);
  endtask : sPriority
  task automatic sStatus();
    wr(mia_pkg::OFF_MASK, 32'h1);
    pulse(8'h00, 8'h02, '0);
    pulse(8'h00, 8'h02, '0);
    tick(2);
    chk(irq, 32'h1);
    rdChk(mia_pkg::OFF_STAT, 32'h3);
    wr(mia_pkg::OFF_MASK, 32'h0);
    tick(1);
    chk(irq, 32'h0);
    wr(mia_pkg::OFF_MASK, 32'h3);
    wr(mia_pkg::OFF_STAT, 32'h1);
    tick(1);
    rdChk(mia_pkg::OFF_STAT, 32'h2);
    chk(irq, 32'h1);
    wr(mia_pkg::OFF_STAT, 32'h2);
    tick(1);
    chk(irq, 32'h0);
    rdChk(mia_pkg::OFF_MASK, 32'h3);
    wr(mia_pkg::OFF_VEC, 32'h0);
  endtask : sStatus
  // reset in mid-run with enables set and endpoints pending
  task automatic sMidReset();
    wr(mia_pkg::OFF_EN, 32'h9F);
    pulse(8'h08, 8'h08, '0);
    rdChk(mia_pkg::OFF_IEP, 32'h08);
    rdChk(mia_pkg::OFF_OEP, 32'h08);
    nrst <= 1'b0;
    tick(2);
    nrst <= 1'b1;
    tick(1);
    rdChk(mia_pkg::OFF_EN, 32'h0);
    rdChk(mia_pkg::OFF_IEP, 32'h0);
    rdChk(mia_pkg::OFF_OEP, 32'h0);
    rdChk(mia_pkg::OFF_VEC, 32'h0);
    rdChk(mia_pkg::OFF_MASK, 32'h0);
    chk({combinedIrqOut_n, coreIrqZeroLine_n}, 32'h3);
    chk({irq, coreIrqReq, coreDispatchAddr}, 32'h0);
  endtask : sMidReset

  // ********************************
  // main sequence and watchdog
  // ********************************
  initial begin
    {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
    {tmrZeroReq, extOneReq, tmrOneReq, serialReq} = 4'h0;
    {inEpEvent, outEpEvent, periphEvent} = '0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    sReset();
    sCore();
    sEndpoint();
    sPriority();
    sStatus();
    sMidReset();
    testDone();
  end
  initial begin
    repeat (20000) @(posedge clk);
    numErrors++;
    $display("Error at %0t: run hung", $time);
    testDone();
  end
endmodule : mcu_interrupt_aggregator_tb
`default_nettype wire
